//--- pms_pkg.sv
// Package: constants and types of the operating-mode sequencer
// Function
// - Exactly one of four modes at any time: stop, start-up, run, breakpoint halt.
// - Stop runs no program and keeps counters, timers, flags and image.
// - Stop inhibits outputs, run indicator off, stop indicator on, except blinking run and off stop during the start-up blink span.
// - Stop to run first starts the start-up routine, unsupervised, may nest calls.
// - Output inhibit stays asserted while the start-up routine runs.
// - Run indicator blinks at least 3 s from start-up begin; stop indicator off, except steady on in breakpoint halt.
// - Start-up routine completion moves the sequencer into run.
// - Run repeats the main cycle routine; interrupt sections may be inserted.
// - Run keeps timers and counters active, refreshes process image each cycle.
// - Run releases output inhibit, run indicator steady once the start-up blink span ends, stop indicator off.
// - Up to 3 breakpoints, set and deleted by the programming tool.
// - Reaching an active breakpoint halts; then step or resume on command.
// - Breakpoint halt blinks run indicator, stop indicator steady on.
// - Halt stops all code levels and freezes timers; real-time clock runs.
// - Halt asserts output inhibit.
// - Halt keeps communication-processor connections established.
// - With more than 2 breakpoints defined, single stepping is refused.
// - Breakpoints accepted in any mode, no test mode needed.
// - Run entry clears input image, start-up, release inhibit; cycle clears, reads, runs.
package pms_pkg;

	// ----------------------------------------
	// Modes and cycle phases
	// ----------------------------------------
	typedef enum logic [1:0] {
		PMS_STOP,
		PMS_STARTUP,
		PMS_RUN,
		PMS_HALT
	} pms_mode_t;

	typedef enum logic [2:0] {
		PMS_PH_CLR_IN,
		PMS_PH_STARTUP,
		PMS_PH_CLR_OUT,
		PMS_PH_READ_IN,
		PMS_PH_MAIN
	} pms_phase_t;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ           = 25_000_000;
	localparam int unsigned BLINK_MIN_MS     = 3000;
	localparam int unsigned BLINK_MIN_CYCLES = BLINK_MIN_MS * (CLK_HZ / 1000);
	localparam int unsigned BLINK_HALF_MS    = 250;
	localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * (CLK_HZ / 1000);
	localparam int unsigned CNT_W            = 27;

	// ----------------------------------------
	// Breakpoints
	// ----------------------------------------
	localparam int unsigned BP_SLOTS     = 3;
	localparam int unsigned BP_STEP_MAX  = 2;
	localparam int unsigned BP_ADDR_W    = 16;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic RST_INHIBIT = 1'b1;
	localparam logic RST_RUN_IND = 1'b0;
	localparam logic RST_STP_IND = 1'b1;

endpackage

//--- pms_bp_slot.sv
// One breakpoint slot: address holder with match output
`timescale 1ns/1ps
module pms_bp_slot (
	// Clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          rstn_i,
	// Tool access
	input  wire logic                          set_i,
	input  wire logic                          clr_i,
	input  wire logic [pms_pkg::BP_ADDR_W-1:0] addr_i,
	// Match
	input  wire logic [pms_pkg::BP_ADDR_W-1:0] pc_i,
	output logic                               used_o,
	output logic                               hit_o
);
	logic                          used;
	logic [pms_pkg::BP_ADDR_W-1:0] addr;
	logic                          next_used;
	logic [pms_pkg::BP_ADDR_W-1:0] next_addr;

	always_comb begin
		next_used = used;
		next_addr = addr;
		if (clr_i) begin
			next_used = 1'b0;
		end else if (set_i) begin
			next_used = 1'b1;
			next_addr = addr_i;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			used <= 1'b0;
			addr <= '0;
		end else begin
			used <= next_used;
			addr <= next_addr;
		end
	end

	assign used_o = used;
	assign hit_o  = used && (addr == pc_i);
endmodule

//--- pms_blinker.sv
// Blink clock and minimum start-up blink timer
`timescale 1ns/1ps
module pms_blinker (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rstn_i,
	// Control
	input  wire logic start_i,
	output logic      blink_o,
	output logic      hold_o
);
	logic [pms_pkg::CNT_W-1:0] half_cnt;
	logic [pms_pkg::CNT_W-1:0] min_cnt;
	logic                      phase;
	logic [pms_pkg::CNT_W-1:0] next_half_cnt;
	logic [pms_pkg::CNT_W-1:0] next_min_cnt;
	logic                      next_phase;

	always_comb begin
		next_half_cnt = half_cnt + 1'b1;
		next_phase    = phase;
		next_min_cnt  = min_cnt;
		if (half_cnt == pms_pkg::CNT_W'(pms_pkg::BLINK_HALF_CYCLES - 1)) begin
			next_half_cnt = '0;
			next_phase    = ~phase;
		end
		// Restart holds the lamp blinking a full span from start-up begin
		if (start_i) begin
			next_min_cnt = pms_pkg::CNT_W'(pms_pkg::BLINK_MIN_CYCLES);
		end else if (min_cnt != '0) begin
			next_min_cnt = min_cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			half_cnt <= '0;
			min_cnt  <= '0;
			phase    <= 1'b0;
		end else begin
			half_cnt <= next_half_cnt;
			min_cnt  <= next_min_cnt;
			phase    <= next_phase;
		end
	end

	assign blink_o = phase;
	assign hold_o  = (min_cnt != '0);
endmodule

//--- pms_sequencer.sv
// Operating-mode sequencer top: modes, output inhibit, lamps, breakpoints
`timescale 1ns/1ps
module pms_sequencer (
	// Clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          rstn_i,
	// Mode requests
	input  wire logic                          run_req_i,
	input  wire logic                          stop_req_i,
	input  wire logic                          error_i,
	// Execution engine
	input  wire logic                          startup_done_i,
	input  wire logic                          cycle_done_i,
	input  wire logic                          stmt_done_i,
	input  wire logic [pms_pkg::BP_ADDR_W-1:0] pc_i,
	// Programming tool
	input  wire logic [2:0]                    bp_set_i,
	input  wire logic [2:0]                    bp_clr_i,
	input  wire logic [pms_pkg::BP_ADDR_W-1:0] bp_addr_i,
	input  wire logic                          bp_active_i,
	input  wire logic                          step_req_i,
	input  wire logic                          resume_req_i,
	// Mode and engine control
	output logic [1:0]                         mode_o,
	output logic                               startup_exec_o,
	output logic                               main_exec_o,
	output logic                               clr_input_image_o,
	output logic                               clr_output_image_o,
	output logic                               read_inputs_o,
	output logic                               timers_run_o,
	output logic                               comm_keep_o,
	output logic                               step_refused_o,
	// Lamps and outputs
	output logic                               output_inhibit_o,
	output logic                               run_indicator_o,
	output logic                               stop_indicator_o
);

	// ----------------------------------------
	// Breakpoint slots
	// ----------------------------------------
	logic [2:0] bp_used;
	logic [2:0] bp_hit;

	for (genvar g = 0; g < pms_pkg::BP_SLOTS; g++) begin : g_bp
		pms_bp_slot u_slot (
			.clk_i  (clk_i),
			.rstn_i (rstn_i),
			.set_i  (bp_set_i[g]),
			.clr_i  (bp_clr_i[g]),
			.addr_i (bp_addr_i),
			.pc_i   (pc_i),
			.used_o (bp_used[g]),
			.hit_o  (bp_hit[g])
		);
	end

	logic [1:0] bp_count;
	logic       bp_reached;
	logic       step_ok;

	always_comb begin
		bp_count = 2'(bp_used[0]) + 2'(bp_used[1]) + 2'(bp_used[2]);
		step_ok  = (bp_count <= 2'(pms_pkg::BP_STEP_MAX));
	end

	// ----------------------------------------
	// Mode and phase state
	// ----------------------------------------
	pms_pkg::pms_mode_t  mode;
	pms_pkg::pms_phase_t phase;
	logic                stepping;
	logic                skip_bp;
	pms_pkg::pms_mode_t  next_mode;
	pms_pkg::pms_phase_t next_phase;
	logic                next_stepping;
	logic                next_skip_bp;
	logic                startup_begin;

	// Resume/step must not re-halt on the same statement it left
	assign bp_reached = bp_active_i && (|bp_hit) && !skip_bp;

	always_comb begin
		next_mode     = mode;
		next_phase    = phase;
		next_stepping = stepping;
		next_skip_bp  = skip_bp && !stmt_done_i;
		startup_begin = 1'b0;
		case (mode)
			pms_pkg::PMS_STOP: begin
				// Program frozen, image kept untouched
				if (run_req_i && !error_i) begin
					next_mode  = pms_pkg::PMS_STARTUP;
					next_phase = pms_pkg::PMS_PH_CLR_IN;
				end
			end
			pms_pkg::PMS_STARTUP: begin
				if (error_i || stop_req_i) begin
					next_mode = pms_pkg::PMS_STOP;
				end else if (phase == pms_pkg::PMS_PH_CLR_IN) begin
					next_phase    = pms_pkg::PMS_PH_STARTUP;
					startup_begin = 1'b1;
				end else if (startup_done_i) begin
					next_mode  = pms_pkg::PMS_RUN;
					next_phase = pms_pkg::PMS_PH_CLR_OUT;
				end
			end
			pms_pkg::PMS_RUN: begin
				if (error_i || stop_req_i) begin
					next_mode = pms_pkg::PMS_STOP;
				end else if (phase == pms_pkg::PMS_PH_MAIN && bp_reached) begin
					next_mode     = pms_pkg::PMS_HALT;
					next_stepping = 1'b0;
				end else if (phase == pms_pkg::PMS_PH_MAIN && stepping && stmt_done_i) begin
					next_mode     = pms_pkg::PMS_HALT;
					next_stepping = 1'b0;
				end else begin
					case (phase)
						pms_pkg::PMS_PH_CLR_OUT: next_phase = pms_pkg::PMS_PH_READ_IN;
						pms_pkg::PMS_PH_READ_IN: next_phase = pms_pkg::PMS_PH_MAIN;
						pms_pkg::PMS_PH_MAIN: begin
							if (cycle_done_i) begin
								next_phase = pms_pkg::PMS_PH_CLR_OUT;
							end
						end
						default: next_phase = pms_pkg::PMS_PH_CLR_OUT;
					endcase
				end
			end
			pms_pkg::PMS_HALT: begin
				if (error_i || stop_req_i) begin
					next_mode = pms_pkg::PMS_STOP;
				end else if (step_req_i && step_ok) begin
					next_mode     = pms_pkg::PMS_RUN;
					next_stepping = 1'b1;
					next_skip_bp  = 1'b1;
				end else if (resume_req_i) begin
					next_mode     = pms_pkg::PMS_RUN;
					next_stepping = 1'b0;
					next_skip_bp  = 1'b1;
				end
			end
			default: next_mode = pms_pkg::PMS_STOP;
		endcase
		if (next_mode == pms_pkg::PMS_STOP) begin
			next_stepping = 1'b0;
			next_skip_bp  = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode     <= pms_pkg::PMS_STOP;
			phase    <= pms_pkg::PMS_PH_CLR_IN;
			stepping <= 1'b0;
			skip_bp  <= 1'b0;
		end else begin
			mode     <= next_mode;
			phase    <= next_phase;
			stepping <= next_stepping;
			skip_bp  <= next_skip_bp;
		end
	end

	// ----------------------------------------
	// Blink timing
	// ----------------------------------------
	logic blink;
	logic blink_hold;

	pms_blinker u_blink (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.start_i (startup_begin),
		.blink_o (blink),
		.hold_o  (blink_hold)
	);

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	logic       next_inhibit;
	logic       next_run_ind;
	logic       next_stop_ind;
	logic       next_startup_exec;
	logic       next_main_exec;
	logic       next_clr_in;
	logic       next_clr_out;
	logic       next_read_in;
	logic       next_timers;
	logic       next_refused;

	always_comb begin
		next_inhibit      = 1'b1;
		next_run_ind      = 1'b0;
		next_stop_ind     = 1'b1;
		next_startup_exec = 1'b0;
		next_main_exec    = 1'b0;
		next_clr_in       = 1'b0;
		next_clr_out      = 1'b0;
		next_read_in      = 1'b0;
		next_timers       = 1'b0;
		next_refused      = (next_mode == pms_pkg::PMS_HALT) && step_req_i && !step_ok;
		case (next_mode)
			pms_pkg::PMS_STOP: begin
				next_inhibit  = 1'b1;
				next_run_ind  = 1'b0;
				next_stop_ind = 1'b1;
			end
			pms_pkg::PMS_STARTUP: begin
				next_inhibit      = 1'b1;
				next_run_ind      = blink;
				next_stop_ind     = 1'b0;
				next_clr_in       = (next_phase == pms_pkg::PMS_PH_CLR_IN);
				next_startup_exec = (next_phase == pms_pkg::PMS_PH_STARTUP);
				next_timers       = 1'b1;
			end
			pms_pkg::PMS_RUN: begin
				next_inhibit   = 1'b0;
				next_run_ind   = 1'b1;
				next_stop_ind  = 1'b0;
				next_clr_out   = (next_phase == pms_pkg::PMS_PH_CLR_OUT);
				next_read_in   = (next_phase == pms_pkg::PMS_PH_READ_IN);
				next_main_exec = (next_phase == pms_pkg::PMS_PH_MAIN);
				next_timers    = 1'b1;
			end
			pms_pkg::PMS_HALT: begin
				next_inhibit  = 1'b1;
				next_run_ind  = blink;
				next_stop_ind = 1'b1;
				next_timers   = 1'b0;
			end
			default: begin
				next_inhibit = 1'b1;
			end
		endcase
		// Lamp keeps blinking through an early stop until the span ends
		if (blink_hold && next_mode != pms_pkg::PMS_HALT) begin
			next_run_ind  = blink;
			next_stop_ind = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			output_inhibit_o   <= pms_pkg::RST_INHIBIT;
			run_indicator_o    <= pms_pkg::RST_RUN_IND;
			stop_indicator_o   <= pms_pkg::RST_STP_IND;
			mode_o             <= 2'h0;
			startup_exec_o     <= 1'b0;
			main_exec_o        <= 1'b0;
			clr_input_image_o  <= 1'b0;
			clr_output_image_o <= 1'b0;
			read_inputs_o      <= 1'b0;
			timers_run_o       <= 1'b0;
			comm_keep_o        <= 1'b1;
			step_refused_o     <= 1'b0;
		end else begin
			output_inhibit_o   <= next_inhibit;
			run_indicator_o    <= next_run_ind;
			stop_indicator_o   <= next_stop_ind;
			mode_o             <= next_mode;
			startup_exec_o     <= next_startup_exec;
			main_exec_o        <= next_main_exec;
			clr_input_image_o  <= next_clr_in;
			clr_output_image_o <= next_clr_out;
			read_inputs_o      <= next_read_in;
			timers_run_o       <= next_timers;
			comm_keep_o        <= 1'b1;
			step_refused_o     <= next_refused;
		end
	end

endmodule

//--- pms_checker.sv
// Checker: port assertions of the operating-mode sequencer
`timescale 1ns/1ps
module pms_checker (
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       rstn_i,
	// Watched inputs
	input wire logic       run_req_i,
	input wire logic       stop_req_i,
	input wire logic       error_i,
	input wire logic       startup_done_i,
	input wire logic       step_req_i,
	// Watched outputs
	input wire logic [1:0] mode_o,
	input wire logic       startup_exec_o,
	input wire logic       main_exec_o,
	input wire logic       clr_input_image_o,
	input wire logic       clr_output_image_o,
	input wire logic       read_inputs_o,
	input wire logic       timers_run_o,
	input wire logic       comm_keep_o,
	input wire logic       step_refused_o,
	input wire logic       output_inhibit_o,
	input wire logic       stop_indicator_o
);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	AST_STOP: assert property (mode_o == 2'h0 |-> output_inhibit_o && !startup_exec_o && !main_exec_o)
		else $error("stop mode executes code or enables outputs");
	AST_SU_INH: assert property (mode_o == 2'h1 |-> output_inhibit_o && !stop_indicator_o)
		else $error("start-up without inhibit or with stop lamp");
	AST_RUN: assert property (mode_o == 2'h2 |-> !output_inhibit_o && timers_run_o)
		else $error("run mode inhibits outputs or freezes timers");
	AST_HALT: assert property (mode_o == 2'h3 |-> output_inhibit_o && !timers_run_o && !main_exec_o)
		else $error("halt mode leaves outputs, timers or code running");
	AST_START: assert property (mode_o == 2'h0 && run_req_i && !error_i && !stop_req_i |=> mode_o == 2'h1 && clr_input_image_o)
		else $error("run request did not enter start-up");
	AST_DONE: assert property (startup_exec_o && startup_done_i && !stop_req_i && !error_i |=> mode_o == 2'h2 && clr_output_image_o)
		else $error("start-up completion did not enter run");
	AST_READ: assert property (clr_output_image_o && !stop_req_i && !error_i |=> read_inputs_o)
		else $error("input read did not follow output clear");
	AST_FORCE_STOP: assert property (stop_req_i || error_i |=> mode_o == 2'h0)
		else $error("stop or error did not force stop mode");
	AST_REFUSE: assert property (step_refused_o |-> mode_o == 2'h3 && $past(step_req_i))
		else $error("step refusal outside a halted step request");
	AST_COMM: assert property (comm_keep_o)
		else $error("connections dropped");

	C_HALT: cover property (mode_o == 2'h2 ##1 mode_o == 2'h3);
	C_REFUSE: cover property (step_refused_o);
	C_STOP: cover property (mode_o == 2'h2 ##1 mode_o == 2'h0);
endmodule

bind pms_sequencer pms_checker chk (.clk_i, .rstn_i, .run_req_i, .stop_req_i, .error_i,
	.startup_done_i, .step_req_i, .mode_o, .startup_exec_o, .main_exec_o, .clr_input_image_o,
	.clr_output_image_o, .read_inputs_o, .timers_run_o, .comm_keep_o, .step_refused_o,
	.output_inhibit_o, .stop_indicator_o);

//--- pms_engine_model.sv
// Execution engine model: start-up routine, main cycle and statement steps
`timescale 1ns/1ps
module pms_engine_model #(
	parameter int SU_LEN  = 8,
	parameter int CYC_LEN = 12
) (
	// Clock and reset
	input wire logic                          clk_i,
	input wire logic                          rstn_i,
	// Control from the sequencer
	input wire logic                          startup_exec_i,
	input wire logic                          main_exec_i,
	input wire logic                          slow_i,
	// Results
	output logic                              startup_done_o,
	output logic                              cycle_done_o,
	output logic                              stmt_done_o,
	output logic [pms_pkg::BP_ADDR_W-1:0]     pc_o
);
	int cnt;

	// Slow start-up is four times longer
	always @(negedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			{startup_done_o, cycle_done_o, stmt_done_o} <= 3'h0;
			pc_o <= '0;
			cnt <= 0;
		end else begin
			{startup_done_o, cycle_done_o, stmt_done_o} <= 3'h0;
			if (!startup_exec_i)
				cnt <= 0;
			if (startup_exec_i && !startup_done_o) begin
				cnt <= cnt + 1;
				if (cnt >= (slow_i ? 4 * SU_LEN : SU_LEN))
					startup_done_o <= 1'b1;
			end else if (main_exec_i && !cycle_done_o) begin
				stmt_done_o <= 1'b1;
				pc_o <= pc_o + 16'h0001;
				if (pc_o == 16'(CYC_LEN - 1)) begin
					cycle_done_o <= 1'b1;
					pc_o <= '0;
				end
			end
		end
	end
endmodule

//--- testbench.sv
// Testbench: mode sequencer driven against the engine model
`timescale 1ns/1ps
module testbench;
	typedef struct packed {
		logic       run;
		logic       stp;
		logic       err;
		logic [7:0] wt;
		logic [1:0] m;
		logic       inh;
	} pms_row_t;
	logic clk_i = 0, rstn_i = 0, run_req_i = 0, stop_req_i = 0, error_i = 0, slow = 0;
	logic bp_active_i = 0, step_req_i = 0, resume_req_i = 0;
	logic startup_done_i, cycle_done_i, stmt_done_i, startup_exec_o, main_exec_o;
	logic [2:0] bp_set_i = 3'h0, bp_clr_i = 3'h0;
	logic [pms_pkg::BP_ADDR_W-1:0] pc_i, bp_addr_i = 16'h0000;
	logic [1:0] mode_o;
	logic clr_input_image_o, clr_output_image_o, read_inputs_o, timers_run_o, comm_keep_o;
	logic step_refused_o, output_inhibit_o, run_indicator_o, stop_indicator_o;
	int miscompares = 0, n_compared = 0, cycles = 0;
	pms_row_t rows [10] = '{
		'{1'b1, 1'b0, 1'b0, 8'h02, 2'h1, 1'b1},
		'{1'b0, 1'b0, 1'b0, 8'h0c, 2'h2, 1'b0},
		'{1'b0, 1'b1, 1'b0, 8'h01, 2'h0, 1'b1},
		'{1'b1, 1'b0, 1'b1, 8'h02, 2'h0, 1'b1},
		'{1'b1, 1'b0, 1'b0, 8'h3c, 2'h2, 1'b0},
		'{1'b1, 1'b0, 1'b0, 8'h02, 2'h2, 1'b0},
		'{1'b0, 1'b1, 1'b0, 8'h01, 2'h0, 1'b1},
		'{1'b1, 1'b0, 1'b0, 8'h02, 2'h1, 1'b1},
		'{1'b0, 1'b0, 1'b1, 8'h01, 2'h0, 1'b1},
		'{1'b1, 1'b0, 1'b0, 8'h3c, 2'h2, 1'b0}};

	pms_sequencer dut (.clk_i, .rstn_i, .run_req_i, .stop_req_i, .error_i, .startup_done_i,
		.cycle_done_i, .stmt_done_i, .pc_i, .bp_set_i, .bp_clr_i, .bp_addr_i, .bp_active_i,
		.step_req_i, .resume_req_i, .mode_o, .startup_exec_o, .main_exec_o, .clr_input_image_o,
		.clr_output_image_o, .read_inputs_o, .timers_run_o, .comm_keep_o, .step_refused_o,
		.output_inhibit_o, .run_indicator_o, .stop_indicator_o);
	pms_engine_model eng (.clk_i, .rstn_i, .startup_exec_i(startup_exec_o),
		.main_exec_i(main_exec_o), .slow_i(slow), .startup_done_o(startup_done_i),
		.cycle_done_o(cycle_done_i), .stmt_done_o(stmt_done_i), .pc_o(pc_i));

	// ----------------------------------------
	// Clock, timeout and helpers
	// ----------------------------------------
	initial begin
		forever #20 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			complete_run();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	// Bounded wait; the caller compares the mode afterwards
	task automatic wait_mode(input logic [1:0] m);
		int k;
		k = 0;
		while (mode_o !== m && k < 200) begin
			@(negedge clk_i);
			k++;
		end
	endtask

	task automatic complete_run;
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		tick(5);
		chk(mode_o, 2'h0);
		chk({output_inhibit_o, run_indicator_o, stop_indicator_o, comm_keep_o}, 4'h b);
		rstn_i = 1'b1;
		for (int i = 0; i < 10; i++) begin
			slow = (i >= 3);
			{run_req_i, stop_req_i, error_i} = {rows[i].run, rows[i].stp, rows[i].err};
			tick(1);
			{run_req_i, stop_req_i, error_i} = 3'h0;
			tick(rows[i].wt);
			chk(mode_o, rows[i].m);
			chk(output_inhibit_o, rows[i].inh);
		end
		chk(timers_run_o, 1'b1);
		// Armed while running, no test mode
		bp_addr_i = 16'h0005;
		bp_set_i = 3'h1;
		bp_active_i = 1'b1;
		tick(1);
		bp_set_i = 3'h0;
		wait_mode(2'h3);
		chk(mode_o, 2'h3);
		chk({output_inhibit_o, timers_run_o, main_exec_o, comm_keep_o}, 4'h9);
		// Blink phase is still low this early after reset
		chk({run_indicator_o, stop_indicator_o}, 2'h1);
		step_req_i = 1'b1;
		tick(1);
		step_req_i = 1'b0;
		chk({step_refused_o, mode_o}, 3'h2);
		wait_mode(2'h3);
		chk(mode_o, 2'h3);
		resume_req_i = 1'b1;
		tick(1);
		resume_req_i = 1'b0;
		chk(mode_o, 2'h2);
		wait_mode(2'h3);
		chk(mode_o, 2'h3);
		// Fill the other two slots; stepping is then refused
		bp_addr_i = 16'h0100;
		bp_set_i = 3'h2;
		tick(1);
		bp_addr_i = 16'h0200;
		bp_set_i = 3'h4;
		tick(1);
		bp_set_i = 3'h0;
		step_req_i = 1'b1;
		tick(1);
		step_req_i = 1'b0;
		chk({step_refused_o, mode_o}, 3'h7);
		tick(1);
		chk(mode_o, 2'h3);
		bp_clr_i = 3'h7;
		stop_req_i = 1'b1;
		tick(1);
		{bp_clr_i, stop_req_i} = 4'h0;
		chk({mode_o, output_inhibit_o, main_exec_o}, 4'h2);
		// Blink span from the last start-up still owns the lamps
		chk({run_indicator_o, stop_indicator_o}, 2'h0);
		// Reset in the middle of start-up
		run_req_i = 1'b1;
		tick(1);
		run_req_i = 1'b0;
		tick(1);
		chk(mode_o, 2'h1);
		rstn_i = 1'b0;
		tick(2);
		chk({mode_o, output_inhibit_o, run_indicator_o, stop_indicator_o}, 5'h05);
		rstn_i = 1'b1;
		tick(2);
		chk({mode_o, output_inhibit_o, run_indicator_o, stop_indicator_o}, 5'h05);
		run_req_i = 1'b1;
		tick(1);
		run_req_i = 1'b0;
		chk({mode_o, startup_exec_o, clr_input_image_o}, 4'h5);
		complete_run();
	end
endmodule
